// ### rtl/amp_gain_ramp_fault_control.sv
/*
 holds the digital control of the class-d output: strap gain decode, dc
 blocker, rate-steered lowpass, volume ramps, clock and supply abort,
 current-limit retry, hi-z shutdown and spread switching.
 assumes a 10 MHz sys_clk, a classic wishbone master, and upstream
 deserializer logic on sys_clk for sampleIn, sampleValid and tdmMode.
*/
`include "amp_consts.svh"

module amp_gain_ramp_fault_control #(
    parameter int ON_CYC = `ON_TIME_MS * (`CLK_HZ / 1000),
    parameter int RAMP_UP_CYC = `RAMP_UP_MS * (`CLK_HZ / 1000),
    parameter int RAMP_DN_CYC = `RAMP_DN_MS * (`CLK_HZ / 1000),
    parameter int RETRY_CYC = `RETRY_MS * (`CLK_HZ / 1000)
) (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic bclk, // bit clock pin
    input wire logic lrclk, // frame clock pin
    input wire logic enPin, // enable pin, high = on
    input wire logic pvddLowLockout, // power supply below lockout
    input wire logic vddLowLockout, // logic supply below lockout
    input wire logic outputCurrentLimit, // current limit comparator
    input wire logic [2:0] strapLevel, // strap level comparator code
    input wire logic tdmMode, // frame format is tdm
    input wire logic [23:0] sampleIn, // selected channel sample
    input wire logic sampleValid, // sampleIn strobe
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte lanes
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone ack
    output logic spkP, // speaker plus level
    output logic spkPOe, // speaker plus drive enable
    output logic spkN, // speaker minus level
    output logic spkNOe, // speaker minus drive enable
    output logic wideband, // wideband filters chosen
    output logic [2:0] slotSel, // tdm slot from strap
    output logic [2:0] gainLevel // decoded full-scale code
);
    localparam int LOSS_CYC = `CLK_LOSS_US * (`CLK_HZ / 1000000);
    localparam int WIDE_CYC = `CLK_HZ / `WIDE_RATE_HZ;
    localparam int UP_STEP = (RAMP_UP_CYC / 255 > 1) ? RAMP_UP_CYC / 255 : 1;
    localparam int DN_STEP = (RAMP_DN_CYC / 255 > 1) ? RAMP_DN_CYC / 255 : 1;
    localparam logic [18:0] ON_LAST = 19'(ON_CYC - 1);
    localparam logic [18:0] RETRY_LAST = 19'(RETRY_CYC - 1);
    localparam logic [15:0] UP_LAST = 16'(UP_STEP - 1);
    localparam logic [15:0] DN_LAST = 16'(DN_STEP - 1);
    localparam logic [11:0] LOSS12 = 12'(LOSS_CYC);
    localparam logic [11:0] WIDE12 = 12'(WIDE_CYC);

    amp_pkg::ctl_s r, next_r;
    logic bclkEdge, lrEdge, lrRise, supOk, abort;
    logic signed [23:0] dcNew, lpNew, scaled1;
    logic signed [33:0] prodA;
    logic signed [32:0] prodB;
    amp_pkg::gain_e gNew;
    logic [8:0] fsNew;
    logic pwmP, pwmN;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        dcNew = '0;
        lpNew = '0;
        prodA = '0;
        prodB = '0;
        scaled1 = '0;
        // two-flop synchronisers; edges seen on the second and third stage
        next_r.bclkS1 = bclk;
        next_r.bclkS2 = r.bclkS1;
        next_r.bclkS3 = r.bclkS2;
        next_r.lrS1 = lrclk;
        next_r.lrS2 = r.lrS1;
        next_r.lrS3 = r.lrS2;
        next_r.enS1 = enPin;
        next_r.enS2 = r.enS1;
        next_r.pvS1 = pvddLowLockout;
        next_r.pvS2 = r.pvS1;
        next_r.vdS1 = vddLowLockout;
        next_r.vdS2 = r.vdS1;
        next_r.ilS1 = outputCurrentLimit;
        next_r.ilS2 = r.ilS1;
        next_r.strapS1 = strapLevel;
        next_r.strapS2 = r.strapS1;
        bclkEdge = r.bclkS2 ^ r.bclkS3;
        lrEdge = r.lrS2 ^ r.lrS3;
        lrRise = r.lrS2 & !r.lrS3;
        supOk = !r.pvS2 && !r.vdS2;

        // clock watchdogs, saturating so a stopped clock stays lost
        next_r.bclkTmo = bclkEdge ? 12'h000 : (r.bclkTmo == 12'hFFF ? r.bclkTmo : r.bclkTmo + 12'h001);
        next_r.lrTmo = lrEdge ? 12'h000 : (r.lrTmo == 12'hFFF ? r.lrTmo : r.lrTmo + 12'h001);
        next_r.clkOk = (r.bclkTmo < LOSS12) && (r.lrTmo < LOSS12);
        abort = !r.clkOk || !supOk;

        // frame period measurement picks the filter set
        next_r.lrCnt = lrRise ? 12'h001 : (r.lrCnt == 12'hFFF ? r.lrCnt : r.lrCnt + 12'h001);
        // the count is zero only in the first cycle after reset, so the partial frame from reset is still taken as a period
        if (lrRise && r.lrCnt != 12'h000) begin
            next_r.ratePeriod = r.lrCnt;
        end
        if (!r.clkOk) begin
            next_r.ratePeriod = 12'h000;
        end
        next_r.wideband = (r.ratePeriod != 12'h000) && (r.ratePeriod < WIDE12);

        // strap decode; read continuously, so a change mid-play clicks
        case (r.strapS2)
            `STRAP_GND: gNew = amp_pkg::DBV_21P5;
            `STRAP_OPEN: gNew = amp_pkg::DBV_18P5;
            `STRAP_VDD: gNew = amp_pkg::DBV_15P5;
            `STRAP_VDD_RES: gNew = amp_pkg::DBV_12P5;
            `STRAP_GND_RES: gNew = amp_pkg::DBV_9P5;
            default: gNew = amp_pkg::DBV_18P5;
        endcase
        if (r.wideband && gNew != amp_pkg::DBV_21P5) begin
            gNew = amp_pkg::DBV_18P5;
        end
        if (tdmMode) begin
            gNew = amp_pkg::DBV_21P5;
        end
        next_r.gainCode = gNew;
        next_r.slotSel = tdmMode ? r.strapS2 : 3'h0;
        case (r.gainCode)
            amp_pkg::DBV_21P5: fsNew = `FS_21P5;
            amp_pkg::DBV_18P5: fsNew = `FS_18P5;
            amp_pkg::DBV_15P5: fsNew = `FS_15P5;
            amp_pkg::DBV_12P5: fsNew = `FS_12P5;
            amp_pkg::DBV_9P5: fsNew = `FS_9P5;
            default: fsNew = `FS_18P5;
        endcase
        next_r.fullScale = fsNew;

        // sample path: dc blocker, rate-steered lowpass, gain and ramp
        if (sampleValid) begin
            dcNew = $signed(sampleIn) - r.xPrev + r.dcY - (r.dcY >>> `DC_SHIFT);
            next_r.xPrev = $signed(sampleIn);
            next_r.dcY = dcNew;
            if (r.wideband) begin
                lpNew = r.lpY + ((dcNew - r.lpY) >>> `LP_SHIFT_WIDE);
            end else begin
                lpNew = r.lpY + ((dcNew - r.lpY) >>> `LP_SHIFT_NARROW);
            end
            next_r.lpY = lpNew;
            prodA = r.lpY * $signed({1'b0, r.fullScale});
            scaled1 = prodA[31:8];
            prodB = scaled1 * $signed({1'b0, r.level});
            next_r.audio = prodB[31:8];
        end
        next_r.duty = r.audio[23:16] ^ 8'h80;

        // power sequencing; every interval counted on sys_clk
        next_r.timer = r.timer + 19'h00001;
        next_r.stepCnt = r.stepCnt + 16'h0001;
        if (abort) begin
            next_r.st = amp_pkg::ST_OFF;
            next_r.level = 8'h00;
            next_r.outEn = 1'b0;
        end else begin
            case (r.st)
                amp_pkg::ST_OFF: begin
                    next_r.outEn = 1'b0;
                    next_r.level = 8'h00;
                    if (r.enS2) begin
                        next_r.st = amp_pkg::ST_WAKE;
                        next_r.timer = 19'h00000;
                        next_r.stepCnt = 16'h0000;
                        next_r.outEn = 1'b1;
                    end
                end
                amp_pkg::ST_WAKE: begin
                    if (!r.enS2) begin
                        next_r.st = r.rampVariant ? amp_pkg::ST_RAMPDN : amp_pkg::ST_OFF;
                        next_r.outEn = r.rampVariant;
                        next_r.stepCnt = 16'h0000;
                    end else if (!r.rampVariant) begin
                        if (r.timer == ON_LAST) begin
                            next_r.st = amp_pkg::ST_PLAY;
                            next_r.level = `LEVEL_MAX;
                        end
                    end else if (r.stepCnt == UP_LAST) begin
                        next_r.stepCnt = 16'h0000;
                        next_r.level = r.level + 8'h01;
                        if (r.level == `LEVEL_MAX - 8'h01) begin
                            next_r.st = amp_pkg::ST_PLAY;
                        end
                    end
                end
                amp_pkg::ST_PLAY: begin
                    if (r.ilS2) begin
                        next_r.st = amp_pkg::ST_FAULT;
                        next_r.timer = 19'h00000;
                        next_r.outEn = 1'b0;
                    end else if (!r.enS2) begin
                        next_r.st = r.rampVariant ? amp_pkg::ST_RAMPDN : amp_pkg::ST_OFF;
                        next_r.outEn = r.rampVariant;
                        next_r.stepCnt = 16'h0000;
                    end
                end
                amp_pkg::ST_RAMPDN: begin
                    if (r.ilS2) begin
                        next_r.st = amp_pkg::ST_FAULT;
                        next_r.timer = 19'h00000;
                        next_r.outEn = 1'b0;
                    end else if (r.level == 8'h00) begin
                        next_r.st = amp_pkg::ST_OFF;
                        next_r.outEn = 1'b0;
                    end else if (r.stepCnt == DN_LAST) begin
                        next_r.stepCnt = 16'h0000;
                        next_r.level = r.level - 8'h01;
                    end
                end
                amp_pkg::ST_FAULT: begin
                    next_r.outEn = 1'b0;
                    if (r.timer == RETRY_LAST) begin
                        // re-enable; a standing fault re-enters next cycle
                        next_r.st = r.enS2 ? amp_pkg::ST_PLAY : amp_pkg::ST_OFF;
                        next_r.outEn = r.enS2;
                    end
                end
                default: begin
                    next_r.st = amp_pkg::ST_OFF;
                    next_r.outEn = 1'b0;
                end
            endcase
        end

        // wishbone slave: ack one cycle after strobe, write lands with ack
        next_r.wbAck = wb_cyc_i && wb_stb_i && !r.wbAck;
        if (wb_cyc_i && wb_stb_i && !r.wbAck) begin
            case (wb_adr_i)
                `REG_CTRL: next_r.wbDat = {31'h0, r.rampVariant};
                `REG_STATUS: next_r.wbDat = {16'h0, r.level, 1'b0, r.outEn, r.wideband, supOk, r.clkOk, r.st};
                `REG_GAIN: next_r.wbDat = {19'h0, r.fullScale, 1'b0, r.gainCode};
                `REG_RATE: next_r.wbDat = {20'h0, r.ratePeriod};
                default: next_r.wbDat = 32'h0;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && r.wbAck && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL) begin
            next_r.rampVariant = wb_dat_i[`CTRL_RAMP_BIT];
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // switching stage
    // ----------------------------------------
    spread_pwm u_pwm (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .duty(r.duty),
        .pwmP(pwmP),
        .pwmN(pwmN),
        .cycleStart()
    );

    // both enables from one flop, so the pair floats in the same cycle
    assign spkP = pwmP;
    assign spkN = pwmN;
    assign spkPOe = r.outEn;
    assign spkNOe = r.outEn;
    assign wb_ack_o = r.wbAck;
    assign wb_dat_o = r.wbDat;
    assign wideband = r.wideband;
    assign slotSel = r.slotSel;
    assign gainLevel = r.gainCode;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    chk_fault_hold_off: assert property (
        (r.st == amp_pkg::ST_FAULT && r.timer != RETRY_LAST && !abort) |=> (r.st == amp_pkg::ST_FAULT && !r.outEn))
        else $error("fault interval cut short");
    chk_fault_retry_on: assert property (
        (r.st == amp_pkg::ST_FAULT && r.timer == RETRY_LAST && !abort && r.enS2) |=> (r.st == amp_pkg::ST_PLAY && spkPOe))
        else $error("no re-enable after fault interval");
    chk_abort_no_ramp: assert property (
        abort |=> (r.st == amp_pkg::ST_OFF && r.level == 8'h00 && !spkPOe))
        else $error("audio not stopped on clock or supply loss");
    chk_off_hiz_pair: assert property (
        (r.st == amp_pkg::ST_OFF) |-> (!spkPOe && !spkNOe))
        else $error("outputs driven in shutdown");
    chk_wide_select: assert property (
        (r.ratePeriod != 12'h000 && r.ratePeriod < WIDE12) |=> wideband)
        else $error("wideband not selected above rate limit");
    chk_wide_gain_set: assert property (
        (r.wideband && !tdmMode) |=> (gainLevel == amp_pkg::DBV_21P5 || gainLevel == amp_pkg::DBV_18P5))
        else $error("illegal gain at high rate");
    chk_tdm_gain_fix: assert property (
        tdmMode |=> (gainLevel == amp_pkg::DBV_21P5))
        else $error("tdm gain not fixed");
    chk_strap_low_gain: assert property (
        (!tdmMode && !r.wideband && r.strapS2 == `STRAP_GND_RES) |=> (gainLevel == amp_pkg::DBV_9P5))
        else $error("resistor-to-ground strap misdecoded");
    chk_fast_turn_on: assert property (
        ($past(r.st) == amp_pkg::ST_WAKE && r.st == amp_pkg::ST_PLAY && !$past(r.rampVariant))
        |-> ($past(r.timer) == ON_LAST && r.level == `LEVEL_MAX))
        else $error("turn-on time wrong");
    chk_ramp_up_step: assert property (
        ($past(r.st) == amp_pkg::ST_WAKE && $past(r.rampVariant) && r.level != $past(r.level) && r.st != amp_pkg::ST_OFF)
        |-> ($past(r.stepCnt) == UP_LAST && r.level == $past(r.level) + 8'h01))
        else $error("ramp-up step timing wrong");
    chk_ramp_dn_mono: assert property (
        ($past(r.st) == amp_pkg::ST_RAMPDN && r.st == amp_pkg::ST_RAMPDN) |-> (r.level <= $past(r.level)))
        else $error("turn-off ramp not monotonic");
    chk_ramp_up_mono: assert property (
        ($past(r.st) == amp_pkg::ST_WAKE && r.st == amp_pkg::ST_WAKE) |-> (r.level >= $past(r.level)))
        else $error("turn-on ramp not monotonic");

    cov_fault_retry: cover property (r.st == amp_pkg::ST_FAULT ##1 r.st == amp_pkg::ST_PLAY);
    cov_ramp_done: cover property (r.st == amp_pkg::ST_RAMPDN ##1 r.st == amp_pkg::ST_OFF);
    cov_play: cover property (r.st == amp_pkg::ST_WAKE ##1 r.st == amp_pkg::ST_PLAY);
    cov_wide: cover property (!wideband ##1 wideband);
endmodule

// ### rtl/amp_consts.svh
/*
 holds the constants of the amplifier control block: times, register map,
 strap codes, gain factors and switching timing.
 assumes a 10 MHz system clock; included by its bare name.
*/
`ifndef AMP_CONSTS_SVH
`define AMP_CONSTS_SVH

// ----------------------------------------
// time base
// ----------------------------------------
`define CLK_HZ 10000000
`define ON_TIME_MS 1
`define RAMP_UP_MS 13
`define RAMP_DN_MS 14
`define RETRY_MS 27
`define CLK_LOSS_US 200
`define WIDE_RATE_HZ 50000

// ----------------------------------------
// register map and fields
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_GAIN 8'h08
`define REG_RATE 8'h0C
`define CTRL_RAMP_BIT 0

// ----------------------------------------
// strap levels, gain factors, filters
// ----------------------------------------
`define STRAP_GND 3'h0
`define STRAP_GND_RES 3'h1
`define STRAP_OPEN 3'h2
`define STRAP_VDD_RES 3'h3
`define STRAP_VDD 3'h4
`define FS_21P5 9'h100
`define FS_18P5 9'h0B5
`define FS_15P5 9'h080
`define FS_12P5 9'h05B
`define FS_9P5 9'h040
`define LEVEL_MAX 8'hFF
`define DC_SHIFT 8
`define LP_SHIFT_NARROW 2
`define LP_SHIFT_WIDE 1

// ----------------------------------------
// switching period in clock cycles
// ----------------------------------------
`define SWITCHING_CENTRE_PER 6'h20
`define SPREAD_DEVIATION 6'h08

`endif

// ### rtl/amp_pkg.sv
/*
 types of the amplifier control block: states, gain codes, state structs.
 assumes nothing beyond a SystemVerilog compiler.
*/
package amp_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_WAKE, ST_PLAY, ST_RAMPDN, ST_FAULT} state_e;
    typedef enum logic [2:0] {DBV_21P5, DBV_18P5, DBV_15P5, DBV_12P5, DBV_9P5} gain_e;

    typedef struct packed {
        logic bclkS1, bclkS2, bclkS3, lrS1, lrS2, lrS3, enS1, enS2;
        logic pvS1, pvS2, vdS1, vdS2, ilS1, ilS2;
        logic [2:0] strapS1, strapS2;
        logic [11:0] bclkTmo, lrTmo, lrCnt, ratePeriod;
        logic clkOk, wideband;
        state_e st;
        logic [18:0] timer;
        logic [15:0] stepCnt;
        logic [7:0] level;
        gain_e gainCode;
        logic [8:0] fullScale;
        logic [2:0] slotSel;
        logic signed [23:0] xPrev, dcY, lpY, audio;
        logic [7:0] duty;
        logic outEn, rampVariant, wbAck;
        logic [31:0] wbDat;
    } ctl_s;

    typedef struct packed {
        logic [7:0] lfsr;
        logic [5:0] cnt, period;
        logic [7:0] dutyLat;
        logic p, n;
    } pwm_s;
endpackage

// ### rtl/spread_pwm.sv
/*
 holds the switching modulator: a complementary pwm pair whose period is
 re-drawn at random around the centre on every switching cycle.
 assumes duty comes from flip-flops on the same clock.
*/
`include "amp_consts.svh"

module spread_pwm (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic [7:0] duty, // offset-binary duty
    output logic pwmP, // positive phase
    output logic pwmN, // negative phase
    output logic cycleStart // first cycle of a period
);
    amp_pkg::pwm_s r, next_r;
    logic [13:0] prod;
    logic [5:0] thr;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        prod = r.dutyLat * r.period;
        thr = prod[13:8];
        next_r.cnt = r.cnt + 6'h01;
        if (r.cnt + 6'h01 >= r.period) begin
            // xnor taps: the all-zero reset state is legal
            next_r.cnt = 6'h00;
            next_r.lfsr = {r.lfsr[6:0], ~(r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3])};
            next_r.period = `SWITCHING_CENTRE_PER - `SPREAD_DEVIATION + {2'h0, r.lfsr[3:0]};
            next_r.dutyLat = duty; // latched per period, no mid-cycle glitch
        end
        next_r.p = r.cnt < thr;
        next_r.n = !(r.cnt < thr);
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pwmP = r.p;
    assign pwmN = r.n;
    assign cycleStart = (r.cnt == 6'h00);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_period_span: assert property (@(posedge sys_clk) disable iff (!nrst)
        (r.period != 6'h00) |-> (r.period >= 6'h18 && r.period <= 6'h27))
        else $error("switching period outside spread band");
    chk_phase_compl: assert property (@(posedge sys_clk) disable iff (!nrst)
        $past(nrst) |-> (r.p != r.n))
        else $error("pwm phases not complementary");
endmodule

// ### sim/audio_host_model.sv
/*
 host side of the serial link: bit clock and 50% duty frame clock.
 assumes the bench sets run and frameBits; the clock stands still when idle.
*/
module audio_host_model (
    input wire logic run, // frames running
    input wire logic [7:0] frameBits, // bit clocks per frame
    output logic bclk, // bit clock
    output logic lrclk // frame clock
);
    timeunit 1ns;
    timeprecision 1ns;
    int k = 0;
    // ----------------------------------------
    // clocks
    // ----------------------------------------
    // frame edge on a falling bit clock, as a real host would launch it
    initial begin
        bclk = 1'b0;
        lrclk = 1'b0;
        forever begin
            if (run) begin
                #400 bclk = 1'b1;
                #400 bclk = 1'b0;
                k = k + 1;
                if (k >= frameBits / 2) begin
                    lrclk = ~lrclk;
                    k = 0;
                end
            end else begin
                #400;
            end
        end
    end
endmodule

// ### sim/testbench.sv
/*
 self-checking bench of the amplifier control block.
 assumes shortened timing parameters and the host model for link clocks.
*/
`include "amp_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ON = 300, UP = 1020, DN = 1275, RTY = 500;
    logic sys_clk = 0, nrst = 0, enPin = 0, pvddLow = 0, vddLow = 0, iLim = 0, tdm = 0, run = 1;
    logic cyc = 0, stb = 0, we = 0, bclk, lrclk, ack, spkP, spkPOe, spkN, spkNOe, wide;
    logic [2:0] strap = 3'h2, slot, gain;
    logic [7:0] adr = 8'h00, frameBits = 8'h20;
    logic [31:0] wdat = 32'h0, rdat, q;
    int err_total = 0, compares = 0;
    always #50 sys_clk = ~sys_clk;
    audio_host_model i_audio_host_model (.run(run), .frameBits(frameBits), .bclk(bclk), .lrclk(lrclk));
    amp_gain_ramp_fault_control #(.ON_CYC(ON), .RAMP_UP_CYC(UP), .RAMP_DN_CYC(DN), .RETRY_CYC(RTY))
    i_amp_gain_ramp_fault_control (.sys_clk(sys_clk), .nrst(nrst), .bclk(bclk), .lrclk(lrclk),
        .enPin(enPin), .pvddLowLockout(pvddLow), .vddLowLockout(vddLow), .outputCurrentLimit(iLim),
        .strapLevel(strap), .tdmMode(tdm), .sampleIn(24'h0), .sampleValid(1'b0), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .spkP(spkP), .spkPOe(spkPOe), .spkN(spkN),
        .spkNOe(spkNOe), .wideband(wide), .slotSel(slot), .gainLevel(gain));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // classic cycle; data taken at the ack edge, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk(32'(n < 20), 1, "ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    // both halves of the bridge must change drive together
    task automatic waitOe(input logic v, input int lim);
        int n = 0;
        while (spkPOe !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        chk(spkPOe, v, "oeP");
        chk(spkNOe, v, "oeN");
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_strap;
        logic [2:0] exp [5] = '{3'h0, 3'h4, 3'h1, 3'h3, 3'h2};
        for (int i = 0; i < 5; i++) begin
            strap <= 3'(i);
            tick(6);
            chk(gain, exp[i], "gain");
        end
        tdm <= 1'b1;
        tick(6);
        chk(gain, 3'h0, "tdmGain");
        chk(slot, 3'h4, "slot");
        tdm <= 1'b0;
    endtask
    // switching period: every cycle inside the spread band, and the period keeps moving
    task automatic t_spread;
        int n = 0, per = 0, lastPer = 0, moves = 0;
        logic prev = 1'b1;
        for (int i = 0; i < 400; i++) begin
            tick(1);
            per++;
            if (spkP === 1'b1 && prev === 1'b0) begin
                if (n > 0) begin
                    chk(32'(per >= `SWITCHING_CENTRE_PER - `SPREAD_DEVIATION), 1, "perLo");
                    chk(32'(per <= `SWITCHING_CENTRE_PER + `SPREAD_DEVIATION), 1, "perHi");
                    if (per != lastPer) begin
                        moves++;
                    end
                end
                n++;
                lastPer = per;
                per = 0;
            end
            prev = spkP;
        end
        chk(32'(moves > 2), 1, "spread");
        chk(32'(spkN === !spkP), 1, "pair");
    endtask
    task automatic t_wide;
        frameBits <= 8'h10;
        tick(800);
        chk(wide, 1, "wide");
        strap <= 3'h3;
        tick(6);
        chk(gain, 3'h1, "wideGain");
        strap <= 3'h0;
        tick(6);
        chk(gain, 3'h0, "wideGain");
        frameBits <= 8'h20;
        strap <= 3'h2;
        tick(800);
        chk(wide, 0, "narrow");
    endtask
    task automatic t_regs;
        wb(1'b0, 8'h10, 0);
        chk(q, 0, "unmapped");
        wb(1'b1, 8'h00, 1);
        wb(1'b0, 8'h00, 0);
        chk(q[0], 1, "ctrl");
        wb(1'b1, 8'h00, 0);
    endtask
    task automatic t_plain;
        enPin <= 1'b1;
        waitOe(1'b1, 20);
        tick(ON - 60);
        wb(1'b0, 8'h04, 0);
        chk(q[2:0], 3'h1, "waking");
        tick(80);
        wb(1'b0, 8'h04, 0);
        chk(q[15:0], 16'hFF5A, "playing");
        enPin <= 1'b0;
        waitOe(1'b0, 20);
    endtask
    task automatic t_ramp;
        wb(1'b1, 8'h00, 1);
        enPin <= 1'b1;
        waitOe(1'b1, 20);
        tick(ON + UP / 2);
        wb(1'b0, 8'h04, 0);
        chk(32'(q[15:8] > 0 && q[15:8] < 8'hFF), 1, "midRamp");
        tick(UP);
        wb(1'b0, 8'h04, 0);
        chk(q[15:8], 8'hFF, "full");
        enPin <= 1'b0;
        tick(DN / 2);
        wb(1'b0, 8'h04, 0);
        chk(q[2:0], 3'h3, "rampDown");
        chk(spkPOe, 1, "stillOn");
        pvddLow <= 1'b1;
        waitOe(1'b0, 6);
        pvddLow <= 1'b0;
        wb(1'b1, 8'h00, 0);
    endtask
    // full turn-off ramp with clocks and supplies kept good: drive holds, then floats
    task automatic t_rampEnd;
        wb(1'b1, 8'h00, 1);
        enPin <= 1'b1;
        tick(UP + 40);
        enPin <= 1'b0;
        tick(DN - 40);
        chk(spkPOe, 1, "rampTail");
        waitOe(1'b0, 80);
        wb(1'b1, 8'h00, 0);
    endtask
    task automatic t_fault;
        enPin <= 1'b1;
        tick(ON + 40);
        iLim <= 1'b1;
        waitOe(1'b0, 8);
        tick(RTY - 40);
        chk(spkPOe, 0, "held");
        waitOe(1'b1, 80);
        waitOe(1'b0, 8);
        iLim <= 1'b0;
        tick(RTY + 40);
        chk(spkPOe, 1, "recovered");
        vddLow <= 1'b1;
        waitOe(1'b0, 6);
        vddLow <= 1'b0;
        enPin <= 1'b0;
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic wrap_up;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // clocks run through reset so the block sees valid frames at once
    initial begin
        tick(16);
        nrst <= 1'b1;
        tick(600);
        t_strap;
        t_spread;
        t_wide;
        t_regs;
        t_plain;
        t_ramp;
        t_rampEnd;
        t_fault;
        wrap_up;
    end
    // watchdog well past the expected run of about 9000 cycles
    initial begin
        tick(40000);
        err_total++;
        wrap_up;
    end
endmodule
